// file: logic/ssc_pkg.sv
package ssc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_TARGET_ADDR  = 8'h08;
  localparam logic [7:0] OFS_IMAGE_REV    = 8'h09;
  localparam logic [7:0] OFS_DEVICE_CONTROL      = 8'h0a;
  localparam logic [7:0] OFS_SW_RESET     = 8'h0c;
  localparam logic [7:0] OFS_MARGIN_HIGH  = 8'h10;
  localparam logic [7:0] OFS_MARGIN_LOW   = 8'h11;

  // ****************************************
  // Device control and software reset fields
  // ****************************************
  localparam int BIT_PDN     = 6;
  localparam int BIT_SPR_HI  = 5;
  localparam int BIT_SPR_LO  = 2;
  localparam int BIT_TRIG    = 1;
  localparam int BIT_AUTO    = 0;
  localparam int BIT_SWRST   = 0;

  // ****************************************
  // Reset values and unmapped read value
  // ****************************************
  localparam logic [6:0] RST_TARGET_ADDR = 7'h59;
  localparam logic [7:0] RST_IMAGE_REV   = 8'h00;
  localparam logic       RST_PDN         = 1'b0;
  localparam logic [3:0] RST_SPARE       = 4'h0;
  localparam logic       RST_TRIG        = 1'b0;
  localparam logic       RST_AUTO        = 1'b1;
  localparam logic [9:0] RST_MARGIN      = 10'h000;
  localparam logic [7:0] RD_UNMAPPED     = 8'h00;

  // ****************************************
  // Bus framing
  // ****************************************
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [6:0] target_addr;
    logic [7:0] image_rev;
    logic [6:0] device_control;
    logic [9:0] margin;
  } ssc_nvm_t;

  typedef struct packed {
    logic       stb;
    logic [7:0] ptr;
    logic [7:0] dat;
  } ssc_wr_t;

  typedef enum logic [2:0] {
    ST_LOAD, ST_CONFIG, ST_HALT, ST_CAL, ST_LOCK, ST_RUN, ST_PDN
  } ssc_state_t;

  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_PTR, PH_WR, PH_RD
  } ssc_phase_t;

endpackage : ssc_pkg

// file: logic/ssc_startup_ctl.sv
// Contract
// (R1) The target address reads in bits 7..1, loaded from memory, default 59h.
// (R2) Bus transfers addressed to the held target address are answered.
// (R3) Image revision reloads from memory after every reset and commit.
// (R4) The power-down bit decides whether the PLL starts after reset.
// (R5) Setting power-down disables the PLL and resets calibration.
// (R6) Clearing power-down re-enables the PLL and restarts calibration.
// (R7) A 0-to-1 change of the calibration trigger starts calibration.
// (R8) The calibration trigger clears itself when calibration completes.
// (R9) In the reset start-up the auto-start bit rules over the trigger.
// (R10) With auto-start set, reset leads to lock and output enable.
// (R11) Power-on, external pin and software reset act alike.
// (R12) With auto-start clear the device halts after configuration.
// (R13) Setting auto-start after such a halt begins the lock sequence.
// (R14) A 10-bit memory-backed margin offset spans two registers.
// (R15) Writes to read-only or reserved bits change nothing, no error.
`timescale 1ns/1ps
`default_nettype none

module ssc_startup_ctl (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              external_reset_pin_low,
  // Two-wire bus
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  // Memory image
  input  wire ssc_pkg::ssc_nvm_t nvm_image_i,
  input  wire logic              nvm_commit_i,
  // Synthesizer
  input  wire logic              cal_done_i,
  input  wire logic              pll_locked_i,
  output logic                   pll_enable_o,
  output logic                   cal_reset_o,
  output logic                   cal_start_o,
  output logic                   output_enable_o
);

  // ****************************************
  // Declarations
  // ****************************************
  logic                scl_s1_q, scl_s2_q, scl_s3_q;
  logic                sda_s1_q, sda_s2_q, sda_s3_q;
  logic                xrst_s1_q, xrst_s2_q;
  logic                bus_start, bus_stop, scl_rise, scl_fall;
  ssc_pkg::ssc_phase_t phase_q;
  logic [3:0]          cnt_q;
  logic                slot_q, rw_q, mack_q, sda_oe_q;
  logic [7:0]          shift_q, ptr_q;
  logic [7:0]          rd_data;
  ssc_pkg::ssc_wr_t    wr_q;
  logic                swrst_q, dev_rst;
  logic [6:0]          addr_q;
  logic [7:0]          rev_q;
  logic                pdn_q, trig_q, trig_d1_q, auto_q;
  logic [3:0]          spare_q;
  logic [9:0]          margin_q;
  ssc_pkg::ssc_state_t state_q, state_d;
  logic                trig_rise;
  logic                pll_en_q, cal_rst_q, cal_start_q, out_en_q;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic wr_hit(input ssc_pkg::ssc_wr_t w,
                                  input logic [7:0] ofs);
    wr_hit = w.stb && (w.ptr == ofs);
  endfunction : wr_hit

  function automatic logic [7:0] rd_byte(input logic [7:0] p);
    case (p)
      ssc_pkg::OFS_TARGET_ADDR: rd_byte = {addr_q, 1'b0};
      ssc_pkg::OFS_IMAGE_REV:   rd_byte = rev_q;
      ssc_pkg::OFS_DEVICE_CONTROL:     rd_byte = {1'b0, pdn_q, spare_q, trig_q,
                                           auto_q};
      ssc_pkg::OFS_MARGIN_HIGH: rd_byte = {6'h00, margin_q[9:8]};
      ssc_pkg::OFS_MARGIN_LOW:  rd_byte = margin_q[7:0];
      default:                  rd_byte = ssc_pkg::RD_UNMAPPED;
    endcase
  endfunction : rd_byte

  // Byte at the pointer, named so its top bit can be picked
  assign rd_data = rd_byte(ptr_q);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Two stages per pin; third stage only feeds edge detection
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
      {xrst_s1_q, xrst_s2_q}         <= 2'h3;
    end else begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_i, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_i, sda_s1_q, sda_s2_q};
      {xrst_s1_q, xrst_s2_q}         <= {external_reset_pin_low, xrst_s1_q};
    end
  end

  // Bus conditions from settled samples
  assign bus_start = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
  assign bus_stop  = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;
  assign scl_rise  = scl_s2_q && !scl_s3_q;
  assign scl_fall  = !scl_s2_q && scl_s3_q;

  // All three reset sources merge into one device reset
  assign dev_rst = !rst_n || !xrst_s2_q || swrst_q; // R11

  // ****************************************
  // Two-wire target
  // ****************************************
  // Bus engine stays up over a software reset so the ack completes
  always_ff @(posedge core_clk) begin
    if (!rst_n || !xrst_s2_q) begin
      phase_q  <= ssc_pkg::PH_IDLE;
      cnt_q    <= 4'h0;
      slot_q   <= 1'b0;
      rw_q     <= 1'b0;
      mack_q   <= 1'b0;
      sda_oe_q <= 1'b0;
      shift_q  <= 8'h00;
      ptr_q    <= 8'h00;
      wr_q     <= '0;
    end else begin
      wr_q.stb <= 1'b0;
      if (bus_start) begin
        phase_q  <= ssc_pkg::PH_ADDR;
        cnt_q    <= 4'h0;
        slot_q   <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (bus_stop) begin
        phase_q  <= ssc_pkg::PH_IDLE;
        sda_oe_q <= 1'b0;
      end else if (phase_q != ssc_pkg::PH_IDLE) begin
        if (scl_rise) begin
          if (slot_q) begin
            mack_q <= !sda_s2_q; // Low means host wants more
          end else if (cnt_q < ssc_pkg::BITS_PER_BYTE) begin
            cnt_q <= cnt_q + 4'h1;
            if (phase_q != ssc_pkg::PH_RD) begin
              shift_q <= {shift_q[6:0], sda_s2_q};
            end
          end
        end else if (scl_fall) begin
          if (slot_q) begin
            // End of ack slot: set up the next byte
            slot_q   <= 1'b0;
            cnt_q    <= 4'h0;
            sda_oe_q <= 1'b0;
            case (phase_q)
              ssc_pkg::PH_ADDR: begin
                if (rw_q) begin
                  phase_q  <= ssc_pkg::PH_RD;
                  shift_q  <= rd_data;
                  sda_oe_q <= !rd_data[7];
                  ptr_q    <= ptr_q + 8'h01;
                end else begin
                  phase_q <= ssc_pkg::PH_PTR;
                end
              end
              ssc_pkg::PH_PTR: phase_q <= ssc_pkg::PH_WR;
              ssc_pkg::PH_RD: begin
                if (mack_q) begin
                  shift_q  <= rd_data;
                  sda_oe_q <= !rd_data[7];
                  ptr_q    <= ptr_q + 8'h01;
                end else begin
                  phase_q <= ssc_pkg::PH_IDLE;
                end
              end
              default: phase_q <= phase_q;
            endcase
          end else if (cnt_q == ssc_pkg::BITS_PER_BYTE) begin
            // Eighth bit done: acknowledge or let go
            slot_q <= 1'b1;
            case (phase_q)
              ssc_pkg::PH_ADDR: begin
                if (shift_q[7:1] == addr_q) begin // R2
                  rw_q     <= shift_q[0];
                  sda_oe_q <= 1'b1;
                end else begin
                  phase_q <= ssc_pkg::PH_IDLE;
                  slot_q  <= 1'b0;
                end
              end
              ssc_pkg::PH_PTR: begin
                ptr_q    <= shift_q;
                sda_oe_q <= 1'b1;
              end
              ssc_pkg::PH_WR: begin
                // Every write is acked, mapped or not
                wr_q     <= '{stb: 1'b1, ptr: ptr_q, dat: shift_q}; // R15
                ptr_q    <= ptr_q + 8'h01;
                sda_oe_q <= 1'b1;
              end
              default: sda_oe_q <= 1'b0; // Host drives its ack
            endcase
          end else if (phase_q == ssc_pkg::PH_RD && cnt_q != 4'h0) begin
            shift_q  <= {shift_q[6:0], 1'b0};
            sda_oe_q <= !shift_q[6];
          end
        end
      end
    end
  end

  // Open drain: only ever pull low
  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_q;

  // ****************************************
  // Software reset
  // ****************************************
  // One-cycle pulse; the register reads back zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      swrst_q <= 1'b0;
    end else begin
      swrst_q <= wr_hit(wr_q, ssc_pkg::OFS_SW_RESET) &&
                 wr_q.dat[ssc_pkg::BIT_SWRST]; // R11
    end
  end

  // ****************************************
  // Memory-backed read-only registers
  // ****************************************
  // Address and margin follow the image only at load; no write path
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      addr_q   <= ssc_pkg::RST_TARGET_ADDR;
      margin_q <= ssc_pkg::RST_MARGIN;
    end else if (state_q == ssc_pkg::ST_LOAD) begin
      addr_q   <= nvm_image_i.target_addr; // R1
      margin_q <= nvm_image_i.margin; // R14
    end
  end

  // Revision also follows every commit
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      rev_q <= ssc_pkg::RST_IMAGE_REV;
    end else if (state_q == ssc_pkg::ST_LOAD || nvm_commit_i) begin
      rev_q <= nvm_image_i.image_rev; // R3
    end
  end

  // ****************************************
  // Device control
  // ****************************************
  // Trigger: set by a write (not during start-up), set wins over clear
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      pdn_q     <= ssc_pkg::RST_PDN;
      spare_q   <= ssc_pkg::RST_SPARE;
      trig_q    <= ssc_pkg::RST_TRIG;
      auto_q    <= ssc_pkg::RST_AUTO;
      trig_d1_q <= ssc_pkg::RST_TRIG;
    end else begin
      trig_d1_q <= trig_q;
      if (state_q == ssc_pkg::ST_LOAD) begin
        pdn_q   <= nvm_image_i.device_control[ssc_pkg::BIT_PDN];
        spare_q <= nvm_image_i.device_control[ssc_pkg::BIT_SPR_HI:
                                       ssc_pkg::BIT_SPR_LO];
        auto_q  <= nvm_image_i.device_control[ssc_pkg::BIT_AUTO];
      end else if (wr_hit(wr_q, ssc_pkg::OFS_DEVICE_CONTROL)) begin
        pdn_q   <= wr_q.dat[ssc_pkg::BIT_PDN];
        spare_q <= wr_q.dat[ssc_pkg::BIT_SPR_HI:ssc_pkg::BIT_SPR_LO];
        auto_q  <= wr_q.dat[ssc_pkg::BIT_AUTO];
      end
      if (wr_hit(wr_q, ssc_pkg::OFS_DEVICE_CONTROL) &&
          wr_q.dat[ssc_pkg::BIT_TRIG] &&
          state_q != ssc_pkg::ST_LOAD &&
          state_q != ssc_pkg::ST_CONFIG) begin // R9
        trig_q <= 1'b1;
      end else if (state_q == ssc_pkg::ST_CAL && cal_done_i) begin
        trig_q <= 1'b0; // R8
      end
    end
  end

  assign trig_rise = trig_q && !trig_d1_q;

  // ****************************************
  // Start-up sequencer
  // ****************************************
  // Power-down overrides every state except the load
  always_comb begin
    state_d = state_q;
    case (state_q)
      ssc_pkg::ST_LOAD: state_d = ssc_pkg::ST_CONFIG;
      ssc_pkg::ST_CONFIG: begin
        if (pdn_q) begin
          state_d = ssc_pkg::ST_PDN; // R4
        end else if (auto_q) begin
          state_d = ssc_pkg::ST_CAL; // R10
        end else begin
          state_d = ssc_pkg::ST_HALT; // R12
        end
      end
      ssc_pkg::ST_HALT: begin
        if (auto_q || trig_rise) begin
          state_d = ssc_pkg::ST_CAL; // R13
        end
      end
      ssc_pkg::ST_CAL: begin
        if (cal_done_i) begin
          state_d = ssc_pkg::ST_LOCK;
        end
      end
      ssc_pkg::ST_LOCK: begin
        if (pll_locked_i) begin
          state_d = ssc_pkg::ST_RUN; // R10
        end else if (trig_rise) begin
          state_d = ssc_pkg::ST_CAL; // R7
        end
      end
      ssc_pkg::ST_RUN: begin
        if (trig_rise) begin
          state_d = ssc_pkg::ST_CAL; // R7
        end
      end
      ssc_pkg::ST_PDN: begin
        if (!pdn_q) begin
          state_d = ssc_pkg::ST_CAL; // R6
        end
      end
      default: state_d = ssc_pkg::ST_LOAD;
    endcase
    if (pdn_q && state_q != ssc_pkg::ST_LOAD) begin
      state_d = ssc_pkg::ST_PDN; // R5
    end
  end

  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      state_q <= ssc_pkg::ST_LOAD;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs registered from the next state
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      pll_en_q    <= 1'b0;
      cal_rst_q   <= 1'b1;
      cal_start_q <= 1'b0;
      out_en_q    <= 1'b0;
    end else begin
      pll_en_q    <= state_d != ssc_pkg::ST_PDN; // R5
      cal_rst_q   <= state_d == ssc_pkg::ST_PDN; // R5
      cal_start_q <= state_d == ssc_pkg::ST_CAL &&
                     state_q != ssc_pkg::ST_CAL;
      out_en_q    <= state_d == ssc_pkg::ST_RUN;
    end
  end

  assign pll_enable_o    = pll_en_q;
  assign cal_reset_o     = cal_rst_q;
  assign cal_start_o     = cal_start_q;
  assign output_enable_o = out_en_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (dev_rst);

  sequence s_cal_kick;
    cal_start_q && state_q == ssc_pkg::ST_CAL;
  endsequence

  sequence s_pdn_hold;
    !pll_en_q && cal_rst_q && state_q == ssc_pkg::ST_PDN;
  endsequence

  a_pdn_disables: assert property ( // R5
    $rose(pdn_q) |=> s_pdn_hold)
    else $error("power-down did not stop the pll");

  a_pdn_restart: assert property ( // R6
    state_q == ssc_pkg::ST_PDN && !pdn_q |=> s_cal_kick)
    else $error("calibration not restarted after power-down");

  a_trig_start: assert property ( // R7
    state_q == ssc_pkg::ST_RUN && trig_rise && !pdn_q |=> s_cal_kick)
    else $error("trigger edge did not start calibration");

  a_trig_clear: assert property ( // R8
    state_q == ssc_pkg::ST_CAL && cal_done_i |=> !trig_q ##0
    state_q != ssc_pkg::ST_CAL)
    else $error("trigger not cleared at calibration end");

  a_auto_start: assert property ( // R10
    state_q == ssc_pkg::ST_CONFIG && auto_q && !pdn_q |=> s_cal_kick)
    else $error("auto-start did not begin calibration");

  a_auto_halt: assert property ( // R12
    state_q == ssc_pkg::ST_CONFIG && !auto_q && !pdn_q |=>
    state_q == ssc_pkg::ST_HALT && !cal_start_q && !out_en_q)
    else $error("device did not halt without auto-start");

  a_halt_resume: assert property ( // R13
    state_q == ssc_pkg::ST_HALT && auto_q && !pdn_q |=> s_cal_kick)
    else $error("auto-start write did not resume lock");

  a_lock_output: assert property ( // R10
    state_q == ssc_pkg::ST_LOCK && pll_locked_i && !pdn_q |=>
    out_en_q ##1 (out_en_q || $past(trig_rise) || pdn_q))
    else $error("output not enabled after lock");

  a_rev_reload: assert property ( // R3
    nvm_commit_i |=> rev_q == $past(nvm_image_i.image_rev))
    else $error("revision not reloaded on commit");

  a_addr_load: assert property ( // R1
    state_q == ssc_pkg::ST_LOAD |=>
    addr_q == $past(nvm_image_i.target_addr) ##1
    addr_q == $past(addr_q))
    else $error("target address not loaded from image");

endmodule : ssc_startup_ctl

`default_nettype wire

// file: tb/ssc_i2c_host.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Two-wire bus host model
// ****************************************
module ssc_i2c_host (
  // Clock
  input  wire logic core_clk,
  // Bus lines, SDA open drain with pull-up
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  // Phase length, twice the minimum so the synchroniser has slack
  localparam int HALF = 8;

  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Changes land just after the edge
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : hold

  // Start or repeated start: SDA falls while SCL high
  task automatic start();
    sda_pull = 1'b0;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_pull = 1'b1;
    hold(HALF);
    scl = 1'b0;
    hold(HALF);
  endtask : start

  // Stop: SDA rises while SCL high
  task automatic stop();
    sda_pull = 1'b1;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_pull = 1'b0;
    hold(HALF);
  endtask : stop

  // One bit; sampled at the end of the high phase
  task automatic clock_bit(input logic tx, output logic rx);
    sda_pull = ~tx;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    rx = sda_line;
    scl = 1'b0;
    hold(HALF);
  endtask : clock_bit

  // Byte, MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic nine_tx,
                      output logic [7:0] rx, output logic nine_rx);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(tx[i], b);
      rx[i] = b;
    end
    clock_bit(nine_tx, nine_rx);
  endtask : xfer

endmodule : ssc_i2c_host
`default_nettype wire

// file: tb/synth_startup_control_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module synth_startup_control_regs_tb;
  localparam logic [6:0] ADDR  = 7'h59;
  localparam int         LIMIT = 60000;

  // ****************************************
  // Stimulus and wiring
  // ****************************************
  logic              core_clk = 1'b0;
  logic              rst_n    = 1'b0;
  logic              pin_low  = 1'b1;
  logic              commit   = 1'b0;
  logic              cal_done = 1'b0;
  logic              locked   = 1'b0;
  ssc_pkg::ssc_nvm_t nvm      = '{7'h59, 8'h3c, 7'h01, 10'h2a5};
  logic scl, sda_pull, sda_o, sda_oe, pll_en, cal_rst, cal_st, out_en;
  logic [7:0] rdat, starts, s;
  logic acked;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  // Open-drain SDA with pull-up
  wire sda_line = ~(sda_pull | (sda_oe & ~sda_o));

  always #10 core_clk = ~core_clk;

  ssc_i2c_host host_u (.core_clk(core_clk), .sda_line(sda_line),
                       .scl(scl), .sda_pull(sda_pull));

  ssc_startup_ctl dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .external_reset_pin_low(pin_low),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .nvm_image_i(nvm), .nvm_commit_i(commit), .cal_done_i(cal_done),
    .pll_locked_i(locked), .pll_enable_o(pll_en), .cal_reset_o(cal_rst),
    .cal_start_o(cal_st), .output_enable_o(out_en));

  // Calibration start pulses, counted one per cycle
  always @(posedge core_clk) begin
    if (!rst_n)
      starts <= 8'h00;
    else if (cal_st === 1'b1)
      starts <= starts + 8'h01;
  end

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      print_verdict();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Pointer write, then data write or repeated start and one read
  task automatic access(input logic [6:0] adr, input logic rd,
                        input logic [7:0] ofs, input logic [7:0] wd);
    logic n;
    host_u.start();
    host_u.xfer({adr, 1'b0}, 1'b1, rdat, n);
    acked = ~n;
    if (acked) begin
      host_u.xfer(ofs, 1'b1, rdat, n);
      if (rd) begin
        host_u.start();
        host_u.xfer({adr, 1'b1}, 1'b1, rdat, n);
        host_u.xfer(8'hff, 1'b1, rdat, n);
      end else begin
        host_u.xfer(wd, 1'b1, rdat, n);
      end
    end
    host_u.stop();
  endtask : access

  task automatic wr(input logic [7:0] ofs, input logic [7:0] wd);
    access(ADDR, 1'b0, ofs, wd);
    check({7'h00, acked}, 8'h01);
  endtask : wr

  task automatic rd(input logic [7:0] ofs);
    access(ADDR, 1'b1, ofs, 8'h00);
  endtask : rd

  // Synthesizer reports calibration done for one cycle
  task automatic done_pulse();
    cal_done = 1'b1;
    tick(1);
    cal_done = 1'b0;
    tick(2);
  endtask : done_pulse

  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    tick(6);
    rst_n = 1'b1;
    tick(6);
    check(starts, 8'h01);
    check({7'h00, pll_en}, 8'h01);
    done_pulse();
    locked = 1'b1;
    tick(3);
    check({7'h00, out_en}, 8'h01);
    // Identity and image registers
    rd(ssc_pkg::OFS_TARGET_ADDR);
    check(rdat, 8'hb2);
    rd(ssc_pkg::OFS_IMAGE_REV);
    check(rdat, 8'h3c);
    rd(ssc_pkg::OFS_MARGIN_HIGH);
    check(rdat, 8'h02);
    rd(ssc_pkg::OFS_MARGIN_LOW);
    check(rdat, 8'ha5);
    // Writes to read-only places are taken and dropped
    wr(ssc_pkg::OFS_TARGET_ADDR, 8'hff);
    rd(ssc_pkg::OFS_TARGET_ADDR);
    check(rdat, 8'hb2);
    wr(ssc_pkg::OFS_MARGIN_HIGH, 8'hfc);
    rd(ssc_pkg::OFS_MARGIN_HIGH);
    check(rdat, 8'h02);
    // Foreign address gets no answer and changes nothing
    access(7'h5a, 1'b0, ssc_pkg::OFS_DEVICE_CONTROL, 8'h40);
    check({7'h00, acked}, 8'h00);
    rd(ssc_pkg::OFS_DEVICE_CONTROL);
    check(rdat, 8'h01);
    // Trigger rise while running, bit stays set until done
    s = starts;
    wr(ssc_pkg::OFS_DEVICE_CONTROL, 8'h03);
    check(starts, s + 8'h01);
    rd(ssc_pkg::OFS_DEVICE_CONTROL);
    check(rdat, 8'h03);
    done_pulse();
    rd(ssc_pkg::OFS_DEVICE_CONTROL);
    check(rdat, 8'h01);
    // Power-down and its release
    wr(ssc_pkg::OFS_DEVICE_CONTROL, 8'h41);
    check({6'h00, pll_en, cal_rst}, 8'h01);
    s = starts;
    wr(ssc_pkg::OFS_DEVICE_CONTROL, 8'h01);
    check({6'h00, pll_en, cal_rst}, 8'h02);
    check(starts, s + 8'h01);
    done_pulse();
    // Spare bits hold, reserved bit 7 reads zero
    wr(ssc_pkg::OFS_DEVICE_CONTROL, 8'hbd);
    rd(ssc_pkg::OFS_DEVICE_CONTROL);
    check(rdat, 8'h3d);
    // Commit reloads the image revision
    nvm.image_rev = 8'h7e;
    commit = 1'b1;
    tick(1);
    commit = 1'b0;
    rd(ssc_pkg::OFS_IMAGE_REV);
    check(rdat, 8'h7e);
    // Software reset with auto-start clear in the image halts
    s = starts;
    nvm.device_control = 7'h00;
    wr(ssc_pkg::OFS_SW_RESET, 8'h01);
    tick(6);
    check({7'h00, out_en}, 8'h00);
    rd(ssc_pkg::OFS_DEVICE_CONTROL);
    check(rdat, 8'h00);
    check(starts, s);
    // Host sets auto-start to leave the halt
    wr(ssc_pkg::OFS_DEVICE_CONTROL, 8'h01);
    check(starts, s + 8'h01);
    done_pulse();
    // External pin reset acts as a device reset
    nvm.device_control = 7'h01;
    nvm.image_rev = 8'h11;
    pin_low = 1'b0;
    tick(6);
    check({7'h00, pll_en}, 8'h00);
    s = starts;
    pin_low = 1'b1;
    tick(10);
    check(starts, s + 8'h01);
    rd(ssc_pkg::OFS_IMAGE_REV);
    check(rdat, 8'h11);
    print_verdict();
  end

endmodule : synth_startup_control_regs_tb
`default_nettype wire
